// ---- core/annp_defines.vh ----
`ifndef ANNP_DEFINES_VH
`define ANNP_DEFINES_VH
// register addresses (5-bit management address)
`define ANNP_ADDR_LP_ABIL 5'h05
`define ANNP_ADDR_EXPAN 5'h06
`define ANNP_ADDR_NP_TX 5'h07
`define ANNP_ADDR_NP_RX 5'h08
`define ANNP_ADDR_PORT_STAT 5'h10
// expansion register bit positions
`define ANNP_EXP_PAGE_RX 1
`define ANNP_EXP_LP_NP_ABLE 2
`define ANNP_EXP_LOCAL_NP_ABLE 3
`define ANNP_EXP_BASE_PAGE 5
// port status bit position
`define ANNP_STAT_PAGE_RX 1
// base page next-page ability bit
`define ANNP_BP_NP_BIT 15
// reset values
`define ANNP_NP_TX_RST 16'h2001
`define ANNP_WORD_RST 16'h0000
`endif

// ---- core/annp_core.v ----
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "annp_defines.vh"

module annp_core (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // local configuration
  input wire local_np_able,
  // negotiation engine, same clock
  input wire an_restart,
  input wire page_rx_valid,
  input wire page_rx_is_base,
  input wire [15:0] page_rx_word,
  input wire np_tx_taken,
  // next page toward engine
  output reg [15:0] np_tx_word,
  output reg np_exchange_en
);

  // ==========================================
  // state
  reg [15:0] np_tx_q;
  reg [15:0] lp_abil_q;
  reg [15:0] np_rx_q;
  reg page_rx_q;
  reg stat_page_rx_q;
  reg lp_np_able_q;
  reg base_page_q;
  reg np_en_q;

  // decoded accesses
  wire rd_exp = reg_rd && (reg_addr == `ANNP_ADDR_EXPAN);
  wire rd_stat = reg_rd && (reg_addr == `ANNP_ADDR_PORT_STAT);
  wire wr_np_tx = reg_wr && (reg_addr == `ANNP_ADDR_NP_TX);
  wire base_rx = page_rx_valid && page_rx_is_base;
  // ignore next pages unless both able
  wire np_rx = page_rx_valid && !page_rx_is_base && np_en_q;
  wire any_rx = base_rx || np_rx;

  // ==========================================
  // transmit next page register
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      np_tx_q <= `ANNP_NP_TX_RST;
    else if (wr_np_tx)
      np_tx_q <= reg_wdata;
  end

  // ==========================================
  // receive page capture
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lp_abil_q <= `ANNP_WORD_RST;
      np_rx_q <= `ANNP_WORD_RST;
    end
    else
    begin
      if (base_rx)
        lp_abil_q <= page_rx_word;
      if (np_rx)
        np_rx_q <= page_rx_word;
    end
  end

  // ==========================================
  // next page exchange enable
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      np_en_q <= 1'b0;
    else if (an_restart)
      np_en_q <= 1'b0;
    else if (base_rx)
      np_en_q <= local_np_able && page_rx_word[`ANNP_BP_NP_BIT];
  end

  // ==========================================
  // sticky page received flags, set wins over read clear
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      page_rx_q <= 1'b0;
      stat_page_rx_q <= 1'b0;
    end
    else
    begin
      if (any_rx)
        page_rx_q <= 1'b1;
      else if (rd_exp)
        page_rx_q <= 1'b0;
      if (any_rx)
        stat_page_rx_q <= 1'b1;
      else if (rd_exp || rd_stat)
        stat_page_rx_q <= 1'b0;
    end
  end

  // ==========================================
  // partner next page able and base page flags
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lp_np_able_q <= 1'b0;
      base_page_q <= 1'b0;
    end
    else
    begin
      if (base_rx && page_rx_word[`ANNP_BP_NP_BIT])
        lp_np_able_q <= 1'b1;
      else if (an_restart || rd_exp)
        lp_np_able_q <= 1'b0;
      if (an_restart)
        base_page_q <= 1'b0;
      else if (any_rx)
        base_page_q <= page_rx_is_base;
    end
  end

  // ==========================================
  // read data, one cycle after strobe
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `ANNP_WORD_RST;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ANNP_ADDR_LP_ABIL: reg_rdata <= lp_abil_q;
        `ANNP_ADDR_NP_TX: reg_rdata <= np_tx_q;
        `ANNP_ADDR_NP_RX: reg_rdata <= np_rx_q;
        `ANNP_ADDR_EXPAN:
        begin
          reg_rdata <= `ANNP_WORD_RST;
          reg_rdata[`ANNP_EXP_PAGE_RX] <= page_rx_q;
          reg_rdata[`ANNP_EXP_LP_NP_ABLE] <= lp_np_able_q;
          reg_rdata[`ANNP_EXP_LOCAL_NP_ABLE] <= local_np_able;
          reg_rdata[`ANNP_EXP_BASE_PAGE] <= base_page_q;
        end
        `ANNP_ADDR_PORT_STAT:
        begin
          reg_rdata <= `ANNP_WORD_RST;
          reg_rdata[`ANNP_STAT_PAGE_RX] <= stat_page_rx_q;
        end
        default: reg_rdata <= `ANNP_WORD_RST;
      endcase
    end
    else
      reg_rdata <= `ANNP_WORD_RST;
  end

  // ==========================================
  // outputs toward negotiation engine
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      np_tx_word <= `ANNP_NP_TX_RST;
      np_exchange_en <= 1'b0;
    end
    else
    begin
      np_tx_word <= wr_np_tx ? reg_wdata : np_tx_q;
      np_exchange_en <= np_en_q && !an_restart;
    end
  end

endmodule // annp_core

// ---- bench/annp_lp_model.sv ----
`timescale 1ns/1ps
// ==========
// link partner page source
module annp_lp_model (
  // clock
  input logic clk,
  // pages toward the port
  output logic valid,
  output logic is_base,
  output logic [15:0] word
);
  initial valid = 0;
  initial is_base = 0;
  initial word = 16'h0000;
  task send(input logic b, input logic [15:0] w);
    @(posedge clk);
    valid <= 1;
    is_base <= b;
    word <= w;
    @(posedge clk);
    valid <= 0;
    word <= ~w; // stale word never shown
  endtask
endmodule // annp_lp_model

// ---- bench/annp_core_assertions.sv ----
`timescale 1ns/1ps
// ==========
// port checker
module annp_chk (
  // clock and reset
  input logic clk,
  input logic rst,
  // watched ports
  input logic [4:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic an_restart,
  input logic page_rx_valid,
  input logic page_rx_is_base,
  input logic [15:0] page_rx_word,
  input logic [15:0] np_tx_word,
  input logic np_exchange_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // quiet gap then expansion read
  sequence s_rd6;
    !reg_rd && !page_rx_valid && !an_restart ##1
    reg_rd && reg_addr == 5'h06 && !page_rx_valid;
  endsequence
  property p_tx;
    reg_wr && reg_addr == 5'h07 |=> np_tx_word == $past(reg_wdata);
  endproperty
  a_tx: assert property (p_tx) else $error("tx word");
  property p_rx;
    page_rx_valid && !page_rx_is_base && np_exchange_en ##1 !page_rx_valid
    ##1 reg_rd && reg_addr == 5'h08 && !page_rx_valid
    |=> reg_rdata == $past(page_rx_word, 3);
  endproperty
  a_rx: assert property (p_rx) else $error("rx word");
  property p_off;
    an_restart && !page_rx_valid |=> !np_exchange_en;
  endproperty
  a_off: assert property (p_off) else $error("np on");
  property p_pr;
    page_rx_valid ##1 s_rd6 |=> reg_rdata[1];
  endproperty
  a_pr: assert property (p_pr) else $error("page flag");
  property p_lp;
    page_rx_valid && page_rx_is_base && page_rx_word[15] ##1 s_rd6
    |=> reg_rdata[2];
  endproperty
  a_lp: assert property (p_lp) else $error("lp able");
  property p_rs;
    an_restart && !page_rx_valid ##1 reg_rd && reg_addr == 5'h06 &&
    !page_rx_valid |=> !reg_rdata[2];
  endproperty
  a_rs: assert property (p_rs) else $error("stale able");
  property p_bp;
    page_rx_valid && page_rx_is_base ##1 s_rd6 |=> reg_rdata[5];
  endproperty
  a_bp: assert property (p_bp) else $error("base flag");
  property p_clr;
    reg_rd && reg_addr == 5'h06 && !page_rx_valid ##1 !page_rx_valid
    ##1 reg_rd && reg_addr == 5'h10 && !page_rx_valid |=> !reg_rdata[1];
  endproperty
  a_clr: assert property (p_clr) else $error("stat clr");
endmodule // annp_chk
bind annp_core annp_chk u_chk (.*);

// ---- bench/annp_core_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h", $time, g); end end
module annp_core_tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, np = 0, rs = 0, v, b, en;
  logic [4:0] a = 0;
  logic [15:0] d = 0, q, w, tx;
  int mismatches = 0, checks = 0;
  always #5 clk = ~clk;
  annp_lp_model u_lp (.clk(clk), .valid(v), .is_base(b), .word(w));
  annp_core u_dut (.clk(clk), .rst(rst), .reg_addr(a), .reg_wdata(d),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(q), .local_np_able(np),
    .an_restart(rs), .page_rx_valid(v), .page_rx_is_base(b),
    .page_rx_word(w), .np_tx_taken(1'b0), .np_tx_word(tx),
    .np_exchange_en(en));
  // one register cycle
  task rg(input logic wn, input logic [4:0] ad, input logic [15:0] dv);
    @(posedge clk);
    wr <= wn;
    rd <= !wn;
    a <= ad;
    d <= dv;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    rs <= 0;
    #1;
  endtask
  task rc(input logic [4:0] ad, input logic [15:0] e);
    rg(0, ad, 16'h0000);
    `CHK(q, e)
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    summarize;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    `CHK(tx, 16'h2001)
    `CHK(q, 16'h0000)
    `CHK(en, 1'b0)
    rst <= 0;
    rg(1, 5'h07, 16'h1234);
    `CHK(tx, 16'h1234)
    np <= 1;
    u_lp.send(1, 16'h8001);
    rc(5'h06, 16'h002e);
    rc(5'h10, 16'h0000);
    rc(5'h05, 16'h8001);
    rc(5'h06, 16'h0028);
    `CHK(en, 1'b1)
    u_lp.send(0, 16'h5a5a);
    rc(5'h08, 16'h5a5a);
    rc(5'h10, 16'h0002);
    rc(5'h10, 16'h0000);
    rc(5'h06, 16'h000a);
    $display("test pages done");
    rs <= 1;
    rc(5'h06, 16'h0008);
    `CHK(en, 1'b0)
    u_lp.send(0, 16'h7777);
    rc(5'h08, 16'h5a5a);
    rc(5'h00, 16'h0000);
    $display("test restart done");
    summarize;
  end
endmodule // annp_core_tb_top
